// >>> design/cie_defines.vh
// constants for the clear-type instruction executor
`ifndef CIE_DEFINES_VH
`define CIE_DEFINES_VH
`define CIE_OP_W 14
`define CIE_CLRREG_MASK 14'h3F80
`define CIE_CLRREG_CODE 14'h0180
`define CIE_CLRACC_MASK 14'h3F80
`define CIE_CLRACC_CODE 14'h0100
`define CIE_WDRST_CODE 14'h0064
`define CIE_WDRST_MASK 14'h3FFF
`define CIE_OP_CLEAR 14'h0000
`define CIE_Q_STEP 2'h1
`define CIE_ADDR_LSB 0
`define CIE_ADDR_MSB 6
`define CIE_Q_LAST 2'h3
`define CIE_Q_FIRST 2'h0
`define CIE_ZERO_BYTE 8'h00
`endif

// >>> design/cie_clear_exec.v
// execution logic for the three clear-type instructions
//
// Behaviour
// - clear-register opcode writes zero into the register at the low seven address bits.
// - clear-register opcode sets zero flag, leaving other status bits untouched.
// - clear-accumulator opcode loads zero into the accumulator, low seven bits ignored.
// - clear-accumulator opcode sets zero flag, other status bits unchanged.
// - watchdog-restart opcode resets the watchdog counter to zero.
// - watchdog-restart opcode also clears the watchdog prescaler count.
// - watchdog-restart opcode sets time-out and power-down status bits to one.
//
// timing
// one instruction cycle is four clk cycles, counted by q_phase
// quarter 0 latches the opcode and its valid bit
// quarters 1 and 2 only let the decode settle
// the strobes are computed on the edge that ends quarter 3
// so they stand high for one clk in quarter 0 of the next instruction
// the next instruction is latched on the edge that ends that quarter 0, as the strobes fall
//
// outputs
// every strobe is a one-cycle pulse from a flip-flop
// register file and accumulator write zero while their strobe is high
// file_addr follows the held opcode every cycle, valid while file_we is high
// zero, time-out and power-down strobes go to the status register outside
// watchdog strobes go to the watchdog counter and its prescaler outside
// the three op strobes tell the core which clear ran
//
// hazards
// the fetch side may change opcode outside quarter 0, so only the held copy is decoded
// an invalid slot latches opcode_valid low and gives no strobe at all
// clear-accumulator ignores its low seven bits, any pattern there decodes
// watchdog restart must match all fourteen bits, it has no free bits
// status bits are not held here, the status register owns them
//
// limits
// no other instruction is decoded here
// reset restarts the quarter count from zero
// a reset in mid-instruction drops that instruction without any strobe
//
`timescale 1ns/1ps
`include "cie_defines.vh"

module cie_clear_exec #(
    parameter ADDR_W = 7,
    parameter DATA_W = 8
) (
    input wire clk,
    input wire rst_n,
    input wire [13:0] opcode,
    input wire opcode_valid,
    output reg [1:0] q_phase,
    output reg file_we,
    output reg [ADDR_W-1:0] file_addr,
    output reg [DATA_W-1:0] file_wdata,
    output reg acc_we,
    output reg [DATA_W-1:0] acc_wdata,
    output reg zero_flag_set,
    output reg watchdog_counter_clr,
    output reg prescaler_clr,
    output reg timeout_status_n_set,
    output reg powerdown_status_n_set,
    output reg clear_file_reg_op,
    output reg clear_accumulator_op,
    output reg watchdog_restart_op
);

    // opcode match against a mask and a code
    function match;
        input [13:0] op;
        input [13:0] mask;
        input [13:0] code;
        begin
            match = ((op & mask) == code);
        end
    endfunction

    // clear-register decode: upper seven bits fixed
    // the low seven bits are the register address
    function dec_clear_file;
        input [13:0] op;
        begin
            dec_clear_file = match(op, `CIE_CLRREG_MASK, `CIE_CLRREG_CODE);
        end
    endfunction

    // clear-accumulator decode: upper seven bits fixed
    // the low seven bits are don't-care
    function dec_clear_acc;
        input [13:0] op;
        begin
            dec_clear_acc = match(op, `CIE_CLRACC_MASK, `CIE_CLRACC_CODE);
        end
    endfunction

    // watchdog-restart decode: every bit must match
    // a near miss must never restart the watchdog
    function dec_restart;
        input [13:0] op;
        begin
            dec_restart = match(op, `CIE_WDRST_MASK, `CIE_WDRST_CODE);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode, latched at the first quarter of each instruction cycle
    reg [13:0] op_hold;
    reg op_ok;
    wire is_clrreg = op_ok && dec_clear_file(op_hold);
    wire is_clracc = op_ok && dec_clear_acc(op_hold);
    wire is_wdrst = op_ok && dec_restart(op_hold);
    wire last_q = (q_phase == `CIE_Q_LAST);

    // quarter counter and opcode capture
    // the counter wraps from 3 to 0, one instruction per four clk
    // the opcode is copied only in quarter 0
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_phase <= `CIE_Q_FIRST;
            op_hold <= `CIE_OP_CLEAR;
            op_ok <= 1'b0;
        end else begin
            q_phase <= q_phase + `CIE_Q_STEP;
            if (q_phase == `CIE_Q_FIRST) begin
                op_hold <= opcode;
                op_ok <= opcode_valid;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next values of the strobes, all low outside the final quarter
    reg next_file_we;
    reg [ADDR_W-1:0] next_file_addr;
    reg next_acc_we;
    reg next_zero_flag_set;
    reg next_watchdog_counter_clr;
    reg next_prescaler_clr;
    reg next_timeout_status_n_set;
    reg next_powerdown_status_n_set;
    reg next_clear_file_reg_op;
    reg next_clear_accumulator_op;
    reg next_watchdog_restart_op;

    // strobe selection for the instruction held since quarter 0
    always @* begin
        next_file_we = 1'b0;
        next_file_addr = op_hold[`CIE_ADDR_MSB:`CIE_ADDR_LSB];
        next_acc_we = 1'b0;
        next_zero_flag_set = 1'b0;
        next_watchdog_counter_clr = 1'b0;
        next_prescaler_clr = 1'b0;
        next_timeout_status_n_set = 1'b0;
        next_powerdown_status_n_set = 1'b0;
        next_clear_file_reg_op = 1'b0;
        next_clear_accumulator_op = 1'b0;
        next_watchdog_restart_op = 1'b0;
        if (last_q) begin
            if (is_clrreg) begin
                next_file_we = 1'b1;
                next_zero_flag_set = 1'b1;
                next_clear_file_reg_op = 1'b1;
            end
            if (is_clracc) begin
                next_acc_we = 1'b1;
                next_zero_flag_set = 1'b1;
                next_clear_accumulator_op = 1'b1;
            end
            if (is_wdrst) begin
                next_watchdog_counter_clr = 1'b1;
                next_prescaler_clr = 1'b1;
                next_timeout_status_n_set = 1'b1;
                next_powerdown_status_n_set = 1'b1;
                next_watchdog_restart_op = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write strobes, one-cycle pulses in quarter 0 of the next instruction
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            file_we <= 1'b0;
            file_addr <= {ADDR_W{1'b0}};
            file_wdata <= {DATA_W{1'b0}};
            acc_we <= 1'b0;
            acc_wdata <= {DATA_W{1'b0}};
            zero_flag_set <= 1'b0;
            watchdog_counter_clr <= 1'b0;
            prescaler_clr <= 1'b0;
            timeout_status_n_set <= 1'b0;
            powerdown_status_n_set <= 1'b0;
            clear_file_reg_op <= 1'b0;
            clear_accumulator_op <= 1'b0;
            watchdog_restart_op <= 1'b0;
        end else begin
            file_we <= next_file_we;
            file_addr <= next_file_addr;
            file_wdata <= {DATA_W{1'b0}};
            acc_we <= next_acc_we;
            acc_wdata <= {DATA_W{1'b0}};
            zero_flag_set <= next_zero_flag_set;
            watchdog_counter_clr <= next_watchdog_counter_clr;
            prescaler_clr <= next_prescaler_clr;
            timeout_status_n_set <= next_timeout_status_n_set;
            powerdown_status_n_set <= next_powerdown_status_n_set;
            clear_file_reg_op <= next_clear_file_reg_op;
            clear_accumulator_op <= next_clear_accumulator_op;
            watchdog_restart_op <= next_watchdog_restart_op;
        end
    end

endmodule // cie_clear_exec

// >>> bench/cie_clear_exec_assertions.sv
// assertions on the clear-type instruction executor
`timescale 1ns/1ps
module cie_chk (input wire clk, rst_n, opcode_valid, file_we, acc_we, zero_flag_set,
    watchdog_counter_clr, prescaler_clr, timeout_status_n_set, powerdown_status_n_set,
    input wire [13:0] opcode, input wire [1:0] q_phase, input wire [7:0] acc_wdata,
    input wire [7:0] file_wdata);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // opcodes as seen on their capture edge
    sequence rg; opcode_valid && !q_phase && opcode[13:7] == 7'h03; endsequence
    sequence ac; opcode_valid && !q_phase && opcode[13:7] == 7'h02; endsequence
    sequence wd; opcode_valid && !q_phase && opcode == 14'h0064; endsequence
    reg_clear_a: assert property (rg |-> ##4 file_we) else $error("clr");
    reg_zero_a: assert property (rg |-> ##4 zero_flag_set) else $error("z");
    reg_only_z_a: assert property (rg |-> ##4 !timeout_status_n_set) else $error("st");
    reg_data_a: assert property (file_we |-> file_wdata == 8'h00) else $error("d");
    acc_clear_a: assert property (ac |-> ##4 acc_we && !acc_wdata) else $error("w");
    acc_zero_a: assert property (ac |-> ##4 zero_flag_set) else $error("z");
    wdt_clear_a: assert property (wd |-> ##4 watchdog_counter_clr) else $error("wd");
    pre_clear_a: assert property (wd |-> ##4 prescaler_clr) else $error("ps");
    wdt_status_a: assert property (wd |-> ##4 timeout_status_n_set && powerdown_status_n_set)
        else $error("st");
    one_cycle_a: assert property (file_we |-> !q_phase ##1 !file_we) else $error("len");
endmodule // cie_chk
bind cie_clear_exec cie_chk i_chk (.*);

// >>> bench/cie_fetch.sv
// fetch-side model presenting one instruction word per instruction cycle
`timescale 1ns/1ps
module cie_fetch (input wire clk, input wire [1:0] q_phase, input wire [13:0] next_op,
    input wire next_valid, output reg [13:0] opcode, output reg opcode_valid);
    // word valid only in the decode quarter, garbage elsewhere
    always @(negedge clk) begin
        opcode <= q_phase == 2'h0 ? next_op : ~opcode;
        opcode_valid <= q_phase == 2'h0 ? next_valid : ~opcode_valid;
    end
endmodule // cie_fetch

// >>> bench/test_clear_instruction_exec.sv
// self-checking bench for the clear-type instruction executor
`timescale 1ns/1ps
module test_clear_instruction_exec;
    reg clk = 0, rst_n = 0, next_valid = 0;
    reg [13:0] next_op = 14'h0000;
    reg [31:0] r;
    reg [16:0] fifo[$];
    integer seed = 22, miscompares = 0, check_count = 0;
    wire opcode_valid, file_we, acc_we, zero_flag_set, watchdog_counter_clr, prescaler_clr;
    wire timeout_status_n_set, powerdown_status_n_set, clear_file_reg_op, clear_accumulator_op;
    wire watchdog_restart_op;
    wire [13:0] opcode;
    wire [1:0] q_phase;
    wire [6:0] file_addr;
    wire [7:0] file_wdata, acc_wdata;
    cie_clear_exec i_dut (.clk(clk), .rst_n(rst_n), .opcode(opcode), .opcode_valid(opcode_valid),
        .q_phase(q_phase), .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata),
        .acc_we(acc_we), .acc_wdata(acc_wdata), .zero_flag_set(zero_flag_set),
        .watchdog_counter_clr(watchdog_counter_clr), .prescaler_clr(prescaler_clr),
        .timeout_status_n_set(timeout_status_n_set),
        .powerdown_status_n_set(powerdown_status_n_set), .clear_file_reg_op(clear_file_reg_op),
        .clear_accumulator_op(clear_accumulator_op), .watchdog_restart_op(watchdog_restart_op));
    cie_fetch i_fetch (.clk(clk), .q_phase(q_phase), .next_op(next_op), .next_valid(next_valid),
        .opcode(opcode), .opcode_valid(opcode_valid));
    initial forever #50 clk = ~clk;
    // pulse pattern expected from one instruction word
    function [16:0] exp_of(input [13:0] op, input v);
        reg f, a, w;
        f = v && op[13:7] == 7'h03;
        a = v && op[13:7] == 7'h02;
        w = v && op == 14'h0064;
        return {f, a, f | a, {4{w}}, f, a, w, f ? op[6:0] : 7'h00};
    endfunction
    task compare_pulses(input [16:0] e, input [16:0] g);
        check_count = check_count + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("BAD at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // take the oldest note at each capture edge
    always @(posedge clk) if (rst_n && q_phase === 2'h0 && fifo.size() > 0)
        compare_pulses(fifo.pop_front(), {file_we, acc_we, zero_flag_set, watchdog_counter_clr,
            prescaler_clr, timeout_status_n_set, powerdown_status_n_set, clear_file_reg_op,
            clear_accumulator_op, watchdog_restart_op, file_we ? file_addr : 7'h00});
    // random mix of the three clears, other words and invalid slots
    initial begin
        fifo.push_back(17'h0);
        fifo.push_back(17'h0);
        repeat (4) @(negedge clk);
        rst_n = 1;
        repeat (800) begin
            @(negedge clk);
            if (q_phase === 2'h0) begin
                fifo.push_back(exp_of(next_op, next_valid));
                r = $random(seed);
                next_op <= r[1] ? (r[0] ? 14'h0064 : r[22:9]) : {6'h01, ~r[0], r[8:2]};
                next_valid <= r[23:20] != 4'h0;
            end
        end
        $display("random clear sequence done");
        finish_test;
    end
endmodule // test_clear_instruction_exec
